// ==== hw/eeg_global_regs.sv ====
// Global EEE indirect register fragment with the wakeup error counter.
// Assumes a byte register port from the switch's serial management logic
// and wakeup pulses from the PHYs, all on the core clock.
`timescale 1ns/1ns

// Functional notes
// - Control bits 7:5 equal 001 select EEE
// - Control bits 3:0 zero select global set
// - Offset register 0x6F holds the byte offset
// - Data register 0xA0 reaches the selected byte
// - Offsets 0x36/0x37 reserved, read 0x0000
// - Offsets 0x38/0x39 read-only limit 0x0201
// - Late PHY wakeup increments wakeup error counter
// - PCS diagnostic register at offsets 0x3A/0x3B
module eeg_global_regs #(
  parameter int PORT_COUNT = 4,
  parameter int ERROR_COUNT_WIDTH = 16,
  parameter int UNIT_CYCLES = eeg_pkg::WAKE_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Byte register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // PHY wakeup events, one bit per port
  input wire logic [PORT_COUNT-1:0] phy_wake_start,
  input wire logic [PORT_COUNT-1:0] phy_wake_done,
  // Wakeup error count
  output logic [ERROR_COUNT_WIDTH-1:0] wake_error_count
);

  ////////////////////////////////////////////////////////////////////////////////
  // Indirect selection

  function automatic logic global_eee_selected(input logic [7:0] ctrl);
    return (ctrl[eeg_pkg::GROUP_MSB:eeg_pkg::GROUP_LSB] == eeg_pkg::GROUP_EEE) &&
      (ctrl[eeg_pkg::PORT_MSB:eeg_pkg::PORT_LSB] == eeg_pkg::PORT_GLOBAL);
  endfunction

  // Bytes outside this fragment read as zero here
  function automatic logic [7:0] indirect_byte(input logic [7:0] ctrl, input logic [7:0] offset);
    logic [7:0] value;
    value = 8'h00;
    if (global_eee_selected(ctrl)) begin
      unique case (offset)
        eeg_pkg::OFS_MIN_LPI_IDLE_CONTROL_HI: value = eeg_pkg::MIN_LPI_IDLE_CONTROL_VALUE[15:8];
        eeg_pkg::OFS_MIN_LPI_IDLE_CONTROL_LO: value = eeg_pkg::MIN_LPI_IDLE_CONTROL_VALUE[7:0];
        eeg_pkg::OFS_WAKEUP_ERROR_THRESHOLD_HI: value = eeg_pkg::WAKEUP_ERROR_THRESHOLD_VALUE[15:8];
        eeg_pkg::OFS_WAKEUP_ERROR_THRESHOLD_LO: value = eeg_pkg::WAKEUP_ERROR_THRESHOLD_VALUE[7:0];
        eeg_pkg::OFS_PCS_DIAGNOSTIC_CONTROL_HI: value = eeg_pkg::PCS_DIAGNOSTIC_CONTROL_VALUE[15:8];
        eeg_pkg::OFS_PCS_DIAGNOSTIC_CONTROL_LO: value = eeg_pkg::PCS_DIAGNOSTIC_CONTROL_VALUE[7:0];
        default: value = 8'h00;
      endcase
    end
    return value;
  endfunction

  logic [7:0] indirect_ctrl;
  logic [7:0] indirect_offset;
  logic [7:0] next_indirect_ctrl;
  logic [7:0] next_indirect_offset;
  logic [7:0] next_reg_rdata;
  logic next_reg_rvalid;

  always_comb begin
    next_indirect_ctrl = indirect_ctrl;
    next_indirect_offset = indirect_offset;
    next_reg_rdata = reg_rdata;
    next_reg_rvalid = reg_read;
    if (reg_write) begin
      unique case (reg_addr)
        eeg_pkg::ADDR_INDIRECT_CTRL: next_indirect_ctrl = reg_wdata;
        eeg_pkg::ADDR_INDIRECT_OFFSET: next_indirect_offset = reg_wdata;
        // Every byte of this fragment is reserved or read-only, so data writes change nothing
        default: next_indirect_ctrl = indirect_ctrl;
      endcase
    end
    if (reg_read) begin
      unique case (reg_addr)
        eeg_pkg::ADDR_INDIRECT_CTRL: next_reg_rdata = indirect_ctrl;
        eeg_pkg::ADDR_INDIRECT_OFFSET: next_reg_rdata = indirect_offset;
        eeg_pkg::ADDR_INDIRECT_DATA: next_reg_rdata = indirect_byte(indirect_ctrl, indirect_offset);
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      indirect_ctrl <= eeg_pkg::CTRL_RESET;
      indirect_offset <= eeg_pkg::OFFSET_RESET;
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      indirect_ctrl <= next_indirect_ctrl;
      indirect_offset <= next_indirect_offset;
      reg_rdata <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wakeup time unit divider

  localparam int UNIT_WIDTH = (UNIT_CYCLES > 1) ? $clog2(UNIT_CYCLES) : 1;
  localparam logic [UNIT_WIDTH-1:0] UNIT_LAST = UNIT_WIDTH'(UNIT_CYCLES - 1);

  logic [UNIT_WIDTH-1:0] unit_count;
  logic [UNIT_WIDTH-1:0] next_unit_count;
  logic unit_tick;

  always_comb begin
    unit_tick = (unit_count == UNIT_LAST);
    next_unit_count = unit_tick ? '0 : unit_count + 1'b1;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      unit_count <= '0;
    end else begin
      unit_count <= next_unit_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-port wakeup timers and the error counter

  logic [PORT_COUNT-1:0] late_pulse;

  genvar port;
  generate
    for (port = 0; port < PORT_COUNT; port++) begin : gen_timer
      eeg_wake_timer #(
        .COUNT_WIDTH(16)
      ) u_timer (
        .clock(clock),
        .rst(rst),
        .unit_tick(unit_tick),
        .limit(eeg_pkg::WAKEUP_ERROR_THRESHOLD_VALUE),
        .wake_start(phy_wake_start[port]),
        .wake_done(phy_wake_done[port]),
        .late_pulse(late_pulse[port])
      );
    end
  endgenerate

  // Several ports may be late in one cycle; each adds one, and the count saturates
  logic [ERROR_COUNT_WIDTH:0] error_sum;
  logic [ERROR_COUNT_WIDTH-1:0] next_wake_error_count;

  always_comb begin
    error_sum = {1'b0, wake_error_count};
    for (int i = 0; i < PORT_COUNT; i++) begin
      error_sum = error_sum + {{ERROR_COUNT_WIDTH{1'b0}}, late_pulse[i]};
    end
    next_wake_error_count = error_sum[ERROR_COUNT_WIDTH] ? '1 : error_sum[ERROR_COUNT_WIDTH-1:0];
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wake_error_count <= '0;
    end else begin
      wake_error_count <= next_wake_error_count;
    end
  end

endmodule

// ==== hw/eeg_pkg.sv ====
// Package for the global EEE indirect register fragment.
// Assumes a byte-wide register port on the switch core clock.
package eeg_pkg;

  // Direct register addresses
  localparam logic [7:0] ADDR_INDIRECT_CTRL = 8'h6e;
  localparam logic [7:0] ADDR_INDIRECT_OFFSET = 8'h6f;
  localparam logic [7:0] ADDR_INDIRECT_DATA = 8'ha0;

  // Indirect control field layout
  localparam int GROUP_MSB = 7;
  localparam int GROUP_LSB = 5;
  localparam int PORT_MSB = 3;
  localparam int PORT_LSB = 0;
  localparam logic [2:0] GROUP_EEE = 3'h1;
  localparam logic [3:0] PORT_GLOBAL = 4'h0;

  // Global EEE byte offsets
  localparam logic [7:0] OFS_MIN_LPI_IDLE_CONTROL_HI = 8'h36;
  localparam logic [7:0] OFS_MIN_LPI_IDLE_CONTROL_LO = 8'h37;
  localparam logic [7:0] OFS_WAKEUP_ERROR_THRESHOLD_HI = 8'h38;
  localparam logic [7:0] OFS_WAKEUP_ERROR_THRESHOLD_LO = 8'h39;
  localparam logic [7:0] OFS_PCS_DIAGNOSTIC_CONTROL_HI = 8'h3a;
  localparam logic [7:0] OFS_PCS_DIAGNOSTIC_CONTROL_LO = 8'h3b;

  // Register contents
  localparam logic [15:0] MIN_LPI_IDLE_CONTROL_VALUE = 16'h0000;
  localparam logic [15:0] WAKEUP_ERROR_THRESHOLD_VALUE = 16'h0201;
  localparam logic [15:0] PCS_DIAGNOSTIC_CONTROL_VALUE = 16'h0000;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] OFFSET_RESET = 8'h00;

  // Wakeup time unit and its length in clock cycles at 250 MHz
  localparam int CLOCK_PERIOD_PS = 4000;
  localparam int WAKE_UNIT_NS = 1;
  localparam int WAKE_UNIT_CYCLES = (WAKE_UNIT_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

  typedef enum logic [1:0] {
    WAKE_IDLE,
    WAKE_TIMING,
    WAKE_LATE
  } eeg_wake_state_type;

endpackage

// ==== hw/eeg_wake_timer.sv ====
// Per-port wakeup timer: measures one low-power-idle exit in time units.
// Assumes wake start and done pulses come from logic on the same clock.
`timescale 1ns/1ns

module eeg_wake_timer #(
  parameter int COUNT_WIDTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Time unit enable and limit
  input wire logic unit_tick,
  input wire logic [COUNT_WIDTH-1:0] limit,
  // Wakeup events
  input wire logic wake_start,
  input wire logic wake_done,
  // Error pulse, one per late wakeup
  output logic late_pulse
);

  eeg_pkg::eeg_wake_state_type state;
  eeg_pkg::eeg_wake_state_type next_state;
  logic [COUNT_WIDTH-1:0] elapsed;
  logic [COUNT_WIDTH-1:0] next_elapsed;
  logic next_late_pulse;

  always_comb begin
    next_state = state;
    next_elapsed = elapsed;
    next_late_pulse = 1'b0;
    unique case (state)
      eeg_pkg::WAKE_IDLE: begin
        if (wake_start) begin
          next_state = eeg_pkg::WAKE_TIMING;
          next_elapsed = '0;
        end
      end
      eeg_pkg::WAKE_TIMING: begin
        if (wake_done) begin
          next_state = eeg_pkg::WAKE_IDLE;
        end else if (unit_tick) begin
          next_elapsed = elapsed + 1'b1;
          // Longer than the limit is late; one error per wakeup
          if (elapsed >= limit) begin
            next_state = eeg_pkg::WAKE_LATE;
            next_late_pulse = 1'b1;
          end
        end
      end
      eeg_pkg::WAKE_LATE: begin
        if (wake_done) begin
          next_state = eeg_pkg::WAKE_IDLE;
        end
      end
      default: begin
        next_state = eeg_pkg::WAKE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= eeg_pkg::WAKE_IDLE;
      elapsed <= '0;
      late_pulse <= 1'b0;
    end else begin
      state <= next_state;
      elapsed <= next_elapsed;
      late_pulse <= next_late_pulse;
    end
  end

endmodule

// ==== bench/eeg_global_regs_chk.sv ====
// Checker for the global EEE indirect register fragment.
// Sees only the top ports; the bind follows the module.
`timescale 1ns/1ns
module eeg_global_regs_chk #(
  parameter int PORT_COUNT = 4,
  parameter int ERROR_COUNT_WIDTH = 16,
  parameter int UNIT_CYCLES = 250
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Wakeup
  input wire logic [PORT_COUNT-1:0] phy_wake_start,
  input wire logic [PORT_COUNT-1:0] phy_wake_done,
  input wire logic [ERROR_COUNT_WIDTH-1:0] wake_error_count
);
  localparam int LATE = 513 * UNIT_CYCLES;
  // Shadow of the select registers, so read checks need no design internals
  logic [7:0] ctrl, ofs, next_ctrl, next_ofs;
  logic [31:0] age, next_age;
  logic sel, rd_a0;
  always_comb begin
    next_ctrl = (reg_write && reg_addr == 8'h6e) ? reg_wdata : ctrl;
    next_ofs = (reg_write && reg_addr == 8'h6f) ? reg_wdata : ofs;
    next_age = (age > LATE) ? age : age + 32'h1;
    sel = ctrl[7:5] == eeg_pkg::GROUP_EEE && ctrl[3:0] == eeg_pkg::PORT_GLOBAL;
    rd_a0 = reg_read && reg_addr == 8'ha0;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl <= 8'h00;
      ofs <= 8'h00;
      age <= 32'h0;
    end else begin
      ctrl <= next_ctrl;
      ofs <= next_ofs;
      age <= next_age;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_RVALID: assert property (reg_read |=> reg_rvalid) else $error("no rvalid after read");
  AST_NO_RVALID: assert property (!reg_read |=> !reg_rvalid) else $error("rvalid without read");
  AST_HOLD: assert property (!reg_read |=> $stable(reg_rdata)) else $error("rdata moved without read");
  AST_DESEL: assert property (rd_a0 && !sel |=> reg_rdata == 8'h00) else $error("deselected byte not zero");
  AST_THR_HI: assert property (rd_a0 && sel && ofs == 8'h38 |=> reg_rdata == 8'h02) else $error("limit hi");
  AST_THR_LO: assert property (rd_a0 && sel && ofs == 8'h39 |=> reg_rdata == 8'h01) else $error("limit lo");
  AST_RSVD: assert property (rd_a0 && sel && ofs inside {8'h36, 8'h37, 8'h3a, 8'h3b} |=> reg_rdata == 8'h00)
    else $error("reserved byte not zero");
  AST_UNMAPPED: assert property (reg_read && !(reg_addr inside {8'h6e, 8'h6f, 8'ha0}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_COUNT_STEP: assert property ((wake_error_count - $past(wake_error_count)) <= PORT_COUNT)
    else $error("error count step wrong");
  AST_COUNT_EARLY: assert property (wake_error_count != $past(wake_error_count) |-> age > LATE)
    else $error("error count too early");
endmodule
bind eeg_global_regs eeg_global_regs_chk #(.PORT_COUNT(PORT_COUNT), .ERROR_COUNT_WIDTH(ERROR_COUNT_WIDTH),
  .UNIT_CYCLES(UNIT_CYCLES)) u_chk (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .phy_wake_start(phy_wake_start), .phy_wake_done(phy_wake_done), .wake_error_count(wake_error_count));

// ==== bench/tb.sv ====
// Self-checking bench for the global EEE indirect register fragment.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/1ns
`define CHK(x, y) begin checks_done++; if ((x) !== (y)) begin n_errors++; $display("[FAIL] %0t %h %h", $time, x, y); end end
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, a, d;
  logic reg_write = 1'b0, reg_read = 1'b0, reg_rvalid;
  logic [3:0] phy_wake_start = 4'h0, phy_wake_done = 4'h0;
  logic [15:0] wake_error_count;
  int n_errors = 0, checks_done = 0, seed = 32'h327a, ctrl = 0, ofs = 0, ecnt = 0, i;
  always #2 clock = ~clock;
  // Unit of one cycle keeps the 0x0201 limit short in simulation
  eeg_global_regs #(.PORT_COUNT(4), .ERROR_COUNT_WIDTH(16), .UNIT_CYCLES(1)) dut (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .phy_wake_start(phy_wake_start),
    .phy_wake_done(phy_wake_done), .wake_error_count(wake_error_count));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    reg_addr = ad;
    reg_wdata = dt;
    reg_read = 1'b0;
    reg_write = 1'b1;
    // Strobe stays up so a following write is back to back; the next rd call or an explicit reg_write = 1'b0 lowers it
    step();
    if (ad == 8'h6e) ctrl = dt;
    if (ad == 8'h6f) ofs = dt;
  endtask
  function automatic logic [7:0] model();
    if (ctrl != 32'h20) return 8'h00;
    if (ofs == 32'h38) return 8'h02;
    if (ofs == 32'h39) return 8'h01;
    return 8'h00;
  endfunction
  // A pause after each read keeps the strobe from being set twice in one step
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    reg_addr = ad;
    reg_write = 1'b0;
    reg_read = 1'b1;
    step();
    reg_read = 1'b0;
    `CHK({reg_rvalid, reg_rdata}, {1'b1, exp})
    step();
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clock);
    #1 rst = 1'b0;
    wr(8'h6e, 8'h20);
    for (i = 32'h36; i <= 32'h3b; i++) begin
      wr(8'h6f, 8'(i));
      wr(8'ha0, 8'hff);
      rd(8'ha0, model());
    end
    wr(8'h6f, 8'h38);
    wr(8'h6e, 8'h40);
    rd(8'ha0, 8'h00);
    wr(8'h6e, 8'h21);
    rd(8'ha0, 8'h00);
    repeat (80) begin
      a = 8'($random(seed));
      d = 8'($random(seed));
      case (a[1:0])
        2'h0: wr(8'h6e, d[0] ? 8'h20 : {d[7:5], 1'b0, d[3:0]});
        2'h1: wr(8'h6f, {4'h3, d[3:0]});
        2'h2: rd(8'ha0, model());
        default: rd(a, (a == 8'h6f) ? 8'(ofs) : 8'h00);
      endcase
    end
    // Two ports late in the same cycle each add one
    reg_write = 1'b0;
    phy_wake_start = 4'h5;
    step();
    phy_wake_start = 4'h0;
    for (i = 0; i < 800 && wake_error_count === 16'(ecnt); i++) step();
    ecnt += 2;
    step();
    `CHK({i == 515, wake_error_count}, {1'b1, 16'(ecnt)})
    phy_wake_done = 4'h7;
    step();
    phy_wake_done = 4'h0;
    phy_wake_start = 4'h2;
    step();
    phy_wake_start = 4'h0;
    repeat (100) step();
    phy_wake_done = 4'h2;
    step();
    phy_wake_done = 4'h0;
    repeat (600) step();
    `CHK(wake_error_count, 16'(ecnt))
    report_and_stop();
  end
endmodule
